/* File: scd_channel.v */
// Chaining DMA channel between the SCSI controller byte bus and local memory.
// Assumes a local bus that answers each request with one ack or berr pulse,
// and decodes DRAM, VMEbus and time-out outside this block.
// Function
// - Holds data pointer, table pointer, 24-bit count
// - Direct mode uses software-loaded pointer and count
// - Chaining fetches address/count pairs from table
// - Other targets end by local bus time-out
// - Sequencer always idle, table walk or transfer
// - Idle after reset until run enable set
// - Back to idle; restart needs errors cleared
// - Table walk first only when select bit set
// - Transfer at data address until count zero
// - Count zero sets done, or walks on link
// - Walk loads block address then count longword
// - Table walk stops on narrow memory
// - Any error: idle, done plus error bit
// - Byte-wide controller bus builds longwords
// - Memory access per full longword, or per short last word at block end
// - One bus cycle per four bytes moved
// - Own sense and drive of SCSI reset
// - Processor reaches controller through pointer register
`timescale 1ns/1ps
`include "scd_consts.vh"

module scd_channel #(parameter AW = 8)
(
   // Clock and reset
   input wire mclk,
   input wire rst_n,
   // Register port
   input wire [AW-1:0] reg_addr,
   input wire [31:0] reg_wdata,
   input wire reg_wr,
   input wire reg_rd,
   output reg [31:0] reg_rdata,
   // Local memory bus
   output reg mem_req,
   output reg mem_we,
   output reg [31:0] mem_addr,
   output reg [2:0] mem_space,
   output reg [3:0] mem_be,
   output reg [31:0] mem_wdata,
   input wire [31:0] mem_rdata,
   input wire mem_ack,
   input wire mem_berr,
   input wire mem_port32,
   // SCSI controller byte bus
   input wire scsi_drq,
   output wire scsi_dack,
   output wire scsi_cs,
   output wire scsi_a0,
   output wire scsi_rd,
   output wire scsi_wr,
   input wire [7:0] scsi_din,
   output wire [7:0] scsi_dout,
   output wire scsi_doe,
   // SCSI bus reset line
   input wire scsi_rst_i,
   output wire scsi_rst_o,
   output wire scsi_rst_oe,
   // Interrupt
   output wire irq
);

   localparam ST_IDLE = 3'b001;
   localparam ST_WALK = 3'b010;
   localparam ST_XFER = 3'b100;

   reg [2:0] state;
   reg walk_half;
   reg [31:0] daddr;
   reg [31:0] taddr;
   reg cnt_link;
   reg [2:0] cnt_space;
   reg [23:0] cnt_bytes;
   reg run_en;
   reg walk_sel;
   reg dir_out;
   reg [2:0] tfc;
   reg rst_drive;
   reg rst_q;
   reg dack_q;

   reg sel_daddr;
   reg sel_taddr;
   reg sel_bcnt;
   reg sel_ctrl;
   reg sel_status;
   reg sel_mask;
   reg sel_rstctl;
   reg sel_sptr;
   reg sel_sdata;
   reg [31:0] flush_word;
   reg [3:0] flush_be;

   wire [31:0] pk_word;
   wire [2:0] pk_cnt;
   wire [`SCD_ST_W-1:0] status;
   wire [`SCD_ST_W-1:0] mask;

   wire st_idle = state[0];
   wire st_walk = state[1];
   wire st_xfer = state[2];

   // Register address decode
   always @*
   begin
      sel_daddr = 1'b0;
      sel_taddr = 1'b0;
      sel_bcnt = 1'b0;
      sel_ctrl = 1'b0;
      sel_status = 1'b0;
      sel_mask = 1'b0;
      sel_rstctl = 1'b0;
      sel_sptr = 1'b0;
      sel_sdata = 1'b0;
      if (reg_addr == `SCD_OFF_DADDR)
         sel_daddr = 1'b1;
      else if (reg_addr == `SCD_OFF_TADDR)
         sel_taddr = 1'b1;
      else if (reg_addr == `SCD_OFF_BCNT)
         sel_bcnt = 1'b1;
      else if (reg_addr == `SCD_OFF_CTRL)
         sel_ctrl = 1'b1;
      else if (reg_addr == `SCD_OFF_STATUS)
         sel_status = 1'b1;
      else if (reg_addr == `SCD_OFF_MASK)
         sel_mask = 1'b1;
      else if (reg_addr == `SCD_OFF_RSTCTL)
         sel_rstctl = 1'b1;
      else if (reg_addr == `SCD_OFF_SCSI_PTR)
         sel_sptr = 1'b1;
      else if (reg_addr == `SCD_OFF_SCSI_DATA)
         sel_sdata = 1'b1;
   end

   // Processor access to the controller, pointer or data register
   wire cpu_sel = sel_sptr | sel_sdata;
   wire cpu_rd = reg_rd & cpu_sel;
   wire cpu_wr = reg_wr & cpu_sel;

   // Start only from idle, with both error bits already cleared
   wire no_err = ~status[`SCD_ST_BERR] & ~status[`SCD_ST_SIZE];
   wire start = reg_wr & sel_ctrl & reg_wdata[`SCD_CTRL_RUN] & st_idle & no_err;

   wire ack_hit = mem_req & mem_ack & ~mem_berr;
   // Time-out on a bad target comes back as berr and ends the run
   wire berr_hit = mem_req & mem_berr & (st_walk | st_xfer);
   wire size_hit = ack_hit & st_walk & ~mem_port32;

   // Byte handshake; the guard cycle lets the controller drop its request
   wire byte_room = dir_out ? (pk_cnt != 3'h0) : (pk_cnt != 3'h4);
   wire dack_go = st_xfer & scsi_drq & ~dack_q & ~cpu_sel & ~(reg_rd | reg_wr) & ~mem_req &
      (cnt_bytes != 24'h00_0000) & byte_room;

   // Longword writes only when the packer is full or the block ends; reads only when it is empty
   wire flush = st_xfer & ~dir_out & ~mem_req &
      ((pk_cnt == 3'h4) | ((cnt_bytes == 24'h00_0000) & (pk_cnt != 3'h0)));
   wire fetch = st_xfer & dir_out & ~mem_req & (pk_cnt == 3'h0) &
      (cnt_bytes != 24'h00_0000);
   wire finish = st_xfer & ~mem_req & (cnt_bytes == 24'h00_0000) &
      (dir_out | (pk_cnt == 3'h0));
   wire fin_done = finish & ~cnt_link;

   wire pk_push = dack_go & ~dir_out;
   wire pk_pop = dack_go & dir_out;
   wire pk_load = ack_hit & st_xfer & dir_out;
   wire pk_clr = (ack_hit & st_xfer & ~dir_out) | finish | berr_hit | size_hit | start;

   wire rst_rise = scsi_rst_i & ~rst_q;
   wire [`SCD_ST_W-1:0] ev = {rst_rise, size_hit, berr_hit,
      fin_done | berr_hit | size_hit};

   // Left-align a short last word and enable only its leading bytes
   always @*
   begin
      flush_word = pk_word;
      flush_be = 4'hF;
      case (pk_cnt)
         3'h1:
         begin
            flush_word = {pk_word[7:0], 24'h00_0000};
            flush_be = 4'h8;
         end
         3'h2:
         begin
            flush_word = {pk_word[15:0], 16'h0000};
            flush_be = 4'hC;
         end
         3'h3:
         begin
            flush_word = {pk_word[23:0], 8'h00};
            flush_be = 4'hE;
         end
         default:
         begin
            flush_word = pk_word;
            flush_be = 4'hF;
         end
      endcase
   end

   // Sequencer and datapath registers
   always @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state <= ST_IDLE;
         walk_half <= 1'b0;
         daddr <= `SCD_RST_ADDR;
         taddr <= `SCD_RST_ADDR;
         cnt_link <= 1'b0;
         cnt_space <= `SCD_RST_SP;
         cnt_bytes <= `SCD_RST_COUNT;
         run_en <= 1'b0;
         walk_sel <= 1'b0;
         dir_out <= 1'b0;
         tfc <= `SCD_RST_SP;
         rst_drive <= 1'b0;
         rst_q <= 1'b0;
         dack_q <= 1'b0;
         mem_req <= 1'b0;
         mem_we <= 1'b0;
         mem_addr <= `SCD_RST_ADDR;
         mem_space <= `SCD_RST_SP;
         mem_be <= 4'h0;
         mem_wdata <= 32'h0000_0000;
      end
      else
      begin
         rst_q <= scsi_rst_i;
         dack_q <= dack_go;
         if (reg_wr & sel_rstctl)
            rst_drive <= reg_wdata[`SCD_RST_DRIVE];
         // Pointers and count are loaded by software only while idle
         if (st_idle & reg_wr)
         begin
            if (sel_daddr)
               daddr <= reg_wdata;
            if (sel_taddr)
               taddr <= reg_wdata;
            if (sel_bcnt)
            begin
               cnt_link <= reg_wdata[`SCD_CNT_LINK];
               cnt_space <= reg_wdata[`SCD_CNT_SP_HI:`SCD_CNT_SP_LO];
               cnt_bytes <= reg_wdata[`SCD_CNT_HI:0];
            end
            if (sel_ctrl)
            begin
               walk_sel <= reg_wdata[`SCD_CTRL_TWS];
               dir_out <= reg_wdata[`SCD_CTRL_DIR];
               tfc <= reg_wdata[`SCD_CTRL_TFC_HI:`SCD_CTRL_TFC_LO];
            end
         end
         if (start)
         begin
            run_en <= 1'b1;
            walk_half <= 1'b0;
            state <= reg_wdata[`SCD_CTRL_TWS] ? ST_WALK : ST_XFER;
         end
         if (dack_go)
            cnt_bytes <= cnt_bytes - 24'h00_0001;
         if (berr_hit | size_hit)
         begin
            mem_req <= 1'b0;
            run_en <= 1'b0;
            state <= ST_IDLE;
         end
         else
         begin
            case (state)
               ST_WALK:
               begin
                  if (!mem_req)
                  begin
                     mem_req <= 1'b1;
                     mem_we <= 1'b0;
                     mem_addr <= walk_half ? taddr + `SCD_STEP_WORD : taddr;
                     mem_space <= tfc;
                     mem_be <= 4'hF;
                  end
                  else if (ack_hit)
                  begin
                     mem_req <= 1'b0;
                     if (!walk_half)
                     begin
                        daddr <= mem_rdata;
                        walk_half <= 1'b1;
                     end
                     else
                     begin
                        cnt_link <= mem_rdata[`SCD_CNT_LINK];
                        cnt_space <= mem_rdata[`SCD_CNT_SP_HI:`SCD_CNT_SP_LO];
                        cnt_bytes <= mem_rdata[`SCD_CNT_HI:0];
                        taddr <= taddr + `SCD_STEP_ENTRY;
                        walk_half <= 1'b0;
                        state <= ST_XFER;
                     end
                  end
               end
               ST_XFER:
               begin
                  if (flush | fetch)
                  begin
                     mem_req <= 1'b1;
                     mem_we <= flush;
                     mem_addr <= daddr;
                     mem_space <= cnt_space;
                     mem_be <= flush ? flush_be : 4'hF;
                     mem_wdata <= flush_word;
                  end
                  else if (ack_hit)
                  begin
                     mem_req <= 1'b0;
                     daddr <= daddr + `SCD_STEP_WORD;
                  end
                  else if (finish)
                  begin
                     if (cnt_link)
                        state <= ST_WALK;
                     else
                     begin
                        run_en <= 1'b0;
                        state <= ST_IDLE;
                     end
                  end
               end
               ST_IDLE:
               begin
                  mem_req <= 1'b0;
               end
               default:
               begin
                  state <= ST_IDLE;
               end
            endcase
         end
      end
   end

   // Register read, answer in the next cycle; unmapped offsets read zero
   always @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
         reg_rdata <= 32'h0000_0000;
      else if (reg_rd)
      begin
         if (sel_daddr)
            reg_rdata <= daddr;
         else if (sel_taddr)
            reg_rdata <= taddr;
         else if (sel_bcnt)
            reg_rdata <= {cnt_link, 4'h0, cnt_space, cnt_bytes};
         else if (sel_ctrl)
            reg_rdata <= {25'h000_0000, tfc, 1'b0, dir_out, walk_sel, run_en};
         else if (sel_status)
            reg_rdata <= {21'h00_0000, state, 4'h0, status};
         else if (sel_mask)
            reg_rdata <= {28'h000_0000, mask};
         else if (sel_rstctl)
            reg_rdata <= {30'h0000_0000, scsi_rst_i, rst_drive};
         else if (cpu_sel)
            reg_rdata <= {24'h00_0000, scsi_din};
         else
            reg_rdata <= 32'h0000_0000;
      end
   end

   scd_packer u_pack
   (
      .mclk(mclk),
      .rst_n(rst_n),
      .clr(pk_clr),
      .push(pk_push),
      .pop(pk_pop),
      .load(pk_load),
      .din_byte(scsi_din),
      .din_word(mem_rdata),
      .word(pk_word),
      .cnt(pk_cnt)
   );

   scd_irq #(.W(`SCD_ST_W)) u_irq
   (
      .mclk(mclk),
      .rst_n(rst_n),
      .ev(ev),
      .wr_status(reg_wr & sel_status),
      .wr_mask(reg_wr & sel_mask),
      .wdata(reg_wdata[`SCD_ST_W-1:0]),
      .status(status),
      .mask(mask),
      .irq(irq)
   );

   // Controller strobes; processor access always wins over a DMA byte
   assign scsi_dack = dack_go;
   assign scsi_cs = cpu_rd | cpu_wr;
   assign scsi_a0 = sel_sdata;
   assign scsi_rd = cpu_rd | pk_push;
   assign scsi_wr = cpu_wr | pk_pop;
   assign scsi_dout = cpu_wr ? reg_wdata[7:0] : pk_word[31:24];
   assign scsi_doe = scsi_wr;
   // Reset line is open drain: drive high while the control bit is set
   assign scsi_rst_o = 1'b1;
   assign scsi_rst_oe = rst_drive;

endmodule

/* File: scd_channel_sva.sv */
// Checker for the chaining DMA channel, watching its top-level ports only.
// Assumes one clock domain and the asynchronous active-low reset.
`timescale 1ns/1ps
`include "scd_consts.vh"
module scd_channel_chk #(parameter AW = 8)
(
   // Clock and reset
   input wire mclk,
   input wire rst_n,
   // Register port
   input wire [AW-1:0] reg_addr,
   input wire [31:0] reg_wdata,
   input wire reg_wr,
   input wire reg_rd,
   // Local memory bus
   input wire mem_req,
   input wire mem_we,
   input wire [31:0] mem_addr,
   input wire mem_ack,
   input wire mem_berr,
   // Controller side
   input wire scsi_dack,
   input wire scsi_cs,
   input wire scsi_a0,
   input wire scsi_rd,
   input wire scsi_wr,
   input wire scsi_doe,
   input wire scsi_rst_o,
   input wire scsi_rst_oe,
   input wire irq
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_n);
   a_req_holds: assert property (mem_req && !(mem_ack || mem_berr)
      |=> mem_req && $stable(mem_addr) && $stable(mem_we))
      else $error("memory request changed before its answer");
   a_req_drops: assert property (mem_req && (mem_ack || mem_berr) |=> !mem_req)
      else $error("memory request held after its answer");
   a_dack_gap: assert property (scsi_dack |=> !scsi_dack)
      else $error("byte transfers without a gap");
   a_dack_blocked: assert property ((reg_rd || reg_wr || mem_req) |-> !scsi_dack)
      else $error("byte transfer during bus or register cycle");
   a_dack_dir: assert property (scsi_dack |-> (scsi_rd != scsi_wr))
      else $error("byte transfer without exactly one direction");
   a_rst_drive: assert property (reg_wr && reg_addr == `SCD_OFF_RSTCTL
      |=> scsi_rst_o && scsi_rst_oe == $past(reg_wdata[`SCD_RST_DRIVE]))
      else $error("reset line drive does not follow control");
   a_ptr_write: assert property (reg_wr && reg_addr == `SCD_OFF_SCSI_PTR
      |-> scsi_cs && !scsi_a0 && scsi_wr && scsi_doe)
      else $error("pointer register write not passed to controller");
   a_data_read: assert property (reg_rd && reg_addr == `SCD_OFF_SCSI_DATA
      |-> scsi_cs && scsi_a0 && scsi_rd && !scsi_wr)
      else $error("data register read not passed to controller");
   a_mask_off: assert property (reg_wr && reg_addr == `SCD_OFF_MASK
      && reg_wdata[3:0] == 4'h0 |=> !irq)
      else $error("interrupt stays high with all sources masked");
endmodule
bind scd_channel scd_channel_chk #(.AW(AW)) i_scd_channel_chk (.mclk, .rst_n, .reg_addr,
   .reg_wdata, .reg_wr, .reg_rd, .mem_req, .mem_we, .mem_addr, .mem_ack, .mem_berr,
   .scsi_dack, .scsi_cs, .scsi_a0, .scsi_rd, .scsi_wr, .scsi_doe, .scsi_rst_o,
   .scsi_rst_oe, .irq);

/* File: scd_consts.vh */
// Constants for the chaining DMA channel: register offsets, fields, resets.
// Included by every design file of the channel; holds definitions only.
`ifndef SCD_CONSTS_VH
`define SCD_CONSTS_VH

// Register offsets on the plain register port
`define SCD_OFF_DADDR 8'h00
`define SCD_OFF_TADDR 8'h04
`define SCD_OFF_BCNT 8'h08
`define SCD_OFF_CTRL 8'h0C
`define SCD_OFF_STATUS 8'h10
`define SCD_OFF_MASK 8'h14
`define SCD_OFF_RSTCTL 8'h18
`define SCD_OFF_SCSI_PTR 8'h20
`define SCD_OFF_SCSI_DATA 8'h24

// System address of the controller's pointer register, decoded on the board
`define SCD_SCSI_PTR_ADDR 32'hFFFE_4000

// Count longword fields
`define SCD_CNT_LINK 31
`define SCD_CNT_SP_HI 26
`define SCD_CNT_SP_LO 24
`define SCD_CNT_HI 23

// Control register fields
`define SCD_CTRL_RUN 0
`define SCD_CTRL_TWS 1
`define SCD_CTRL_DIR 2
`define SCD_CTRL_TFC_HI 6
`define SCD_CTRL_TFC_LO 4

// Status and mask bits
`define SCD_ST_DONE 0
`define SCD_ST_BERR 1
`define SCD_ST_SIZE 2
`define SCD_ST_RST 3
`define SCD_ST_W 4

// Reset control fields
`define SCD_RST_DRIVE 0
`define SCD_RST_SENSE 1

// Reset values
`define SCD_RST_ADDR 32'h0000_0000
`define SCD_RST_COUNT 24'h00_0000
`define SCD_RST_SP 3'h0
`define SCD_RST_STATUS 4'h0
`define SCD_RST_MASK 4'h0

// Address steps
`define SCD_STEP_WORD 32'h0000_0004
`define SCD_STEP_ENTRY 32'h0000_0008

`endif

/* File: scd_irq.v */
// Sticky event status, mask and level interrupt for the DMA channel.
// Assumes event inputs are one-cycle pulses; software clears by writing ones.
`timescale 1ns/1ps
`include "scd_consts.vh"

module scd_irq #(parameter W = `SCD_ST_W)
(
   // Clock and reset
   input wire mclk,
   input wire rst_n,
   // Events and software access
   input wire [W-1:0] ev,
   input wire wr_status,
   input wire wr_mask,
   input wire [W-1:0] wdata,
   // State
   output reg [W-1:0] status,
   output reg [W-1:0] mask,
   output wire irq
);

   always @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         status <= `SCD_RST_STATUS;
         mask <= `SCD_RST_MASK;
      end
      else
      begin
         // A new event beats a clear in the same cycle
         status <= (status & ~(wr_status ? wdata : {W{1'b0}})) | ev;
         if (wr_mask)
            mask <= wdata;
      end
   end

   assign irq = |(status & mask);

endmodule

/* File: scd_mem_model.sv */
// Partner model: local memory answering the channel, plus the controller byte side.
// Assumes one request at a time and that the bench preloads the memory words it uses.
`timescale 1ns/1ps
module scd_mem_model
(
   // Clock and reset
   input wire mclk,
   input wire rst_n,
   // Scenario controls
   input wire slow,
   input wire berr_en,
   input wire narrow,
   input wire drq_en,
   // Local memory bus
   input wire mem_req,
   input wire mem_we,
   input wire [31:0] mem_addr,
   input wire [2:0] mem_space,
   input wire [3:0] mem_be,
   input wire [31:0] mem_wdata,
   output wire [31:0] mem_rdata,
   output reg mem_ack,
   output reg mem_berr,
   output wire mem_port32,
   // Controller byte bus
   output wire scsi_drq,
   input wire scsi_dack,
   input wire scsi_rd,
   input wire scsi_wr,
   input wire [7:0] scsi_dout,
   output wire [7:0] scsi_din
);
   reg [31:0] mem [0:63];
   reg [31:0] out_sh;
   reg [7:0] nxt_byte;
   reg [2:0] wait_cnt;
   reg [2:0] last_space;
   reg [2:0] rd_space;
   integer nreq;
   wire [5:0] idx = mem_addr[7:2];
   wire [31:0] bm = {{8{mem_be[3]}}, {8{mem_be[2]}}, {8{mem_be[1]}}, {8{mem_be[0]}}};
   wire answer = mem_req && !mem_ack && !mem_berr && (!slow || wait_cnt == 3'd3);
   // Released lines show the inverse so stale data never passes for valid data
   assign mem_rdata = mem_ack ? mem[idx] : ~mem[idx];
   assign mem_port32 = !narrow;
   assign scsi_drq = drq_en;
   assign scsi_din = scsi_rd ? nxt_byte : ~nxt_byte;
   always @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         mem_ack <= 1'b0;
         mem_berr <= 1'b0;
         wait_cnt <= 3'd0;
         nreq <= 0;
         nxt_byte <= 8'h11;
         out_sh <= 32'h0000_0000;
         last_space <= 3'd0;
         rd_space <= 3'd0;
      end
      else
      begin
         mem_ack <= answer && !berr_en;
         mem_berr <= answer && berr_en;
         wait_cnt <= (mem_req && !answer && !mem_ack) ? wait_cnt + 3'd1 : 3'd0;
         if (answer)
            nreq <= nreq + 1;
         if (mem_ack && mem_we)
         begin
            mem[idx] <= (mem_wdata & bm) | (mem[idx] & ~bm);
            last_space <= mem_space;
         end
         if (mem_ack && !mem_we)
            rd_space <= mem_space;
         if (scsi_dack && scsi_rd)
            nxt_byte <= nxt_byte + 8'h11;
         if (scsi_dack && scsi_wr)
            out_sh <= {out_sh[23:0], scsi_dout};
      end
   end
endmodule

/* File: scd_packer.v */
// Byte to longword packer and unpacker for the SCSI data path.
// Assumes one operation per cycle from its owner; first byte sits in bits 31:24.
`timescale 1ns/1ps
`include "scd_consts.vh"

module scd_packer
(
   // Clock and reset
   input wire mclk,
   input wire rst_n,
   // Controls
   input wire clr,
   input wire push,
   input wire pop,
   input wire load,
   // Data
   input wire [7:0] din_byte,
   input wire [31:0] din_word,
   output reg [31:0] word,
   output reg [2:0] cnt
);

   always @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         word <= 32'h0000_0000;
         cnt <= 3'h0;
      end
      else if (clr)
      begin
         word <= 32'h0000_0000;
         cnt <= 3'h0;
      end
      else if (load)
      begin
         word <= din_word;
         cnt <= 3'h4;
      end
      else if (push)
      begin
         word <= {word[23:0], din_byte};
         cnt <= cnt + 3'h1;
      end
      else if (pop)
      begin
         word <= {word[23:0], 8'h00};
         cnt <= cnt - 3'h1;
      end
   end

endmodule

/* File: test_scsi_chaining_dma_channel.sv */
// Self-checking bench for the chaining DMA channel and its memory partner.
// Assumes register reads answer one cycle later and the partner never stalls registers.
`timescale 1ns/1ps
`include "scd_consts.vh"
module test_scsi_chaining_dma_channel;
   reg mclk = 1'b0;
   reg rst_n = 1'b0;
   reg [7:0] reg_addr = 8'h00;
   reg [31:0] reg_wdata = 32'h0000_0000;
   reg reg_wr = 1'b0;
   reg reg_rd = 1'b0;
   reg scsi_rst_i = 1'b0;
   reg slow = 1'b0;
   reg berr_en = 1'b0;
   reg narrow = 1'b0;
   reg drq_en = 1'b0;
   wire [31:0] reg_rdata, mem_addr, mem_wdata, mem_rdata;
   wire [2:0] mem_space;
   wire [3:0] mem_be;
   wire [7:0] scsi_din, scsi_dout;
   wire mem_req, mem_we, mem_ack, mem_berr, mem_port32, scsi_drq, scsi_dack, scsi_cs;
   wire scsi_a0, scsi_rd, scsi_wr, scsi_doe, scsi_rst_o, scsi_rst_oe, irq;
   integer miscompares = 0;
   integer cmp_count = 0;
   integer i, n0;
   reg [31:0] rv;
   reg [71:0] rows [0:5];
   always #20 mclk = ~mclk;
   scd_channel i_scd_channel (.mclk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
      .reg_rdata, .mem_req, .mem_we, .mem_addr, .mem_space, .mem_be, .mem_wdata,
      .mem_rdata, .mem_ack, .mem_berr, .mem_port32, .scsi_drq, .scsi_dack, .scsi_cs,
      .scsi_a0, .scsi_rd, .scsi_wr, .scsi_din, .scsi_dout, .scsi_doe, .scsi_rst_i,
      .scsi_rst_o, .scsi_rst_oe, .irq);
   scd_mem_model i_scd_mem_model (.mclk, .rst_n, .slow, .berr_en, .narrow, .drq_en,
      .mem_req, .mem_we, .mem_addr, .mem_space, .mem_be, .mem_wdata, .mem_rdata,
      .mem_ack, .mem_berr, .mem_port32, .scsi_drq, .scsi_dack, .scsi_rd, .scsi_wr,
      .scsi_dout, .scsi_din);
   task end_of_test;
      begin
         if (miscompares == 0 && cmp_count > 0)
            $display("All tests passed");
         else
            $display("Some tests failed");
         $finish;
      end
   endtask
   task chk(input string nm, input [31:0] seen, input [31:0] exp);
      begin
         cmp_count = cmp_count + 1;
         if (seen !== exp)
         begin
            miscompares = miscompares + 1;
            $display("MISMATCH %0s expected %h seen %h", nm, exp, seen);
         end
      end
   endtask
   // Settle time after the edge keeps flag checks clear of the update race
   task wr(input [7:0] a, input [31:0] d);
      begin
         @(posedge mclk);
         reg_addr <= a;
         reg_wdata <= d;
         reg_wr <= 1'b1;
         @(posedge mclk);
         reg_wr <= 1'b0;
         #1;
      end
   endtask
   task rd(input [7:0] a, output [31:0] d);
      begin
         @(posedge mclk);
         reg_addr <= a;
         reg_rd <= 1'b1;
         @(posedge mclk);
         reg_rd <= 1'b0;
         #1;
         d = reg_rdata;
      end
   endtask
   task start(input [31:0] da, input [31:0] cnt, input [31:0] ctl);
      integer k;
      begin
         wr(`SCD_OFF_DADDR, da);
         wr(`SCD_OFF_BCNT, cnt);
         n0 = i_scd_mem_model.nreq;
         wr(`SCD_OFF_CTRL, ctl);
         rv = 32'h0000_0000;
         for (k = 0; k < 400 && rv[8] !== 1'b1; k = k + 1)
            rd(`SCD_OFF_STATUS, rv);
         if (rv[8] !== 1'b1)
         begin
            miscompares = miscompares + 1;
            end_of_test;
         end
      end
   endtask
   initial
   begin
      repeat (50000) @(posedge mclk);
      miscompares = miscompares + 1;
      end_of_test;
   end
   initial
   begin
      rows[0] = {`SCD_OFF_DADDR, 32'h1234_5678, 32'h1234_5678};
      rows[1] = {`SCD_OFF_TADDR, 32'hFFFF_FFF8, 32'hFFFF_FFF8};
      rows[2] = {`SCD_OFF_BCNT, 32'h87FF_FFFF, 32'h87FF_FFFF};
      rows[3] = {`SCD_OFF_MASK, 32'h0000_000F, 32'h0000_000F};
      rows[4] = {`SCD_OFF_MASK, 32'h0000_0000, 32'h0000_0000};
      rows[5] = {8'h30, 32'hFFFF_FFFF, 32'h0000_0000};
      repeat (20) @(posedge mclk);
      rst_n <= 1'b1;
      for (i = 0; i < 6; i = i + 1)
      begin
         wr(rows[i][71:64], rows[i][63:32]);
         rd(rows[i][71:64], rv);
         chk("register row", rv, rows[i][31:0]);
      end
      @(posedge mclk);
      rst_n <= 1'b0;
      repeat (2) @(posedge mclk);
      rst_n <= 1'b1;
      rd(`SCD_OFF_BCNT, rv);
      chk("count after reset", rv, 32'h0000_0000);
      rd(`SCD_OFF_STATUS, rv);
      chk("status after reset", rv, 32'h0000_0100);
      i_scd_mem_model.mem[32] = 32'h0000_0000;
      drq_en <= 1'b1;
      wr(`SCD_OFF_MASK, 32'h0000_0001);
      start(32'h0000_0080, 32'h0100_0004, 32'h0000_0001);
      chk("packed word", i_scd_mem_model.mem[32], 32'h1122_3344);
      chk("bus cycles", i_scd_mem_model.nreq - n0, 1);
      chk("data space", i_scd_mem_model.last_space, 32'h0000_0001);
      rd(`SCD_OFF_DADDR, rv);
      chk("data address", rv, 32'h0000_0084);
      rd(`SCD_OFF_STATUS, rv);
      chk("status done", rv, 32'h0000_0101);
      chk("irq on done", irq, 1);
      wr(`SCD_OFF_STATUS, 32'h0000_0001);
      chk("irq cleared", irq, 0);
      start(32'h0000_0080, 32'h0100_0004, 32'h0000_0005);
      chk("bytes out", i_scd_mem_model.out_sh, 32'h1122_3344);
      chk("read cycles", i_scd_mem_model.nreq - n0, 1);
      wr(`SCD_OFF_STATUS, 32'h0000_0001);
      // Two linked entries; the second ends the chain
      i_scd_mem_model.mem[16] = 32'h0000_00C0;
      i_scd_mem_model.mem[17] = 32'h8200_0004;
      i_scd_mem_model.mem[18] = 32'h0000_00E0;
      i_scd_mem_model.mem[19] = 32'h0300_0004;
      slow <= 1'b1;
      wr(`SCD_OFF_TADDR, 32'h0000_0040);
      start(32'h0000_0000, 32'h0000_0000, 32'h0000_0053);
      chk("block one", i_scd_mem_model.mem[48], 32'h5566_7788);
      chk("block two", i_scd_mem_model.mem[56], 32'h99AA_BBCC);
      chk("chain cycles", i_scd_mem_model.nreq - n0, 6);
      chk("table space", i_scd_mem_model.rd_space, 32'h0000_0005);
      chk("entry space", i_scd_mem_model.last_space, 32'h0000_0003);
      rd(`SCD_OFF_TADDR, rv);
      chk("table address", rv, 32'h0000_0050);
      rd(`SCD_OFF_DADDR, rv);
      chk("block address", rv, 32'h0000_00E4);
      wr(`SCD_OFF_STATUS, 32'h0000_0001);
      berr_en <= 1'b1;
      start(32'h0000_0080, 32'h0100_0004, 32'h0000_0001);
      rd(`SCD_OFF_STATUS, rv);
      chk("bus error", rv, 32'h0000_0103);
      n0 = i_scd_mem_model.nreq;
      wr(`SCD_OFF_CTRL, 32'h0000_0001);
      repeat (10) @(posedge mclk);
      rd(`SCD_OFF_STATUS, rv);
      chk("no restart", rv, 32'h0000_0103);
      chk("no cycles", i_scd_mem_model.nreq - n0, 0);
      wr(`SCD_OFF_STATUS, 32'h0000_0003);
      berr_en <= 1'b0;
      narrow <= 1'b1;
      wr(`SCD_OFF_TADDR, 32'h0000_0040);
      start(32'h0000_0000, 32'h0000_0000, 32'h0000_0053);
      rd(`SCD_OFF_STATUS, rv);
      chk("narrow table", rv, 32'h0000_0105);
      chk("walk stopped", i_scd_mem_model.nreq - n0, 1);
      wr(`SCD_OFF_STATUS, 32'h0000_0005);
      narrow <= 1'b0;
      scsi_rst_i <= 1'b1;
      repeat (3) @(posedge mclk);
      rd(`SCD_OFF_STATUS, rv);
      chk("reset seen", rv, 32'h0000_0108);
      rd(`SCD_OFF_RSTCTL, rv);
      chk("reset sensed", rv, 32'h0000_0002);
      wr(`SCD_OFF_RSTCTL, 32'h0000_0001);
      chk("reset driven", {scsi_rst_o, scsi_rst_oe}, 32'h0000_0003);
      wr(`SCD_OFF_MASK, 32'h0000_0008);
      chk("irq unmasked", irq, 1);
      wr(`SCD_OFF_MASK, 32'h0000_0000);
      chk("irq masked", irq, 0);
      wr(`SCD_OFF_RSTCTL, 32'h0000_0000);
      wr(`SCD_OFF_SCSI_PTR, 32'h0000_0015);
      rd(`SCD_OFF_SCSI_DATA, rv);
      chk("controller byte", rv[7:0], 32'h0000_0021);
      i_scd_mem_model.mem[36] = 32'h0000_00FF;
      start(32'h0000_0090, 32'h0000_0003, 32'h0000_0001);
      chk("short word", i_scd_mem_model.mem[36], 32'h2132_43FF);
      end_of_test;
   end
endmodule
